// ===== design/gated_flop_params.svh
// Constants for the dual gated edge flop
`ifndef GATED_FLOP_PARAMS_SVH
`define GATED_FLOP_PARAMS_SVH
`define CHANNEL_COUNT 2
`define CLEAR_LEVEL   1'h0
`define CLEARED_VALUE 1'h0
`endif

// ===== design/gated_flop_pkg.sv
// Types for the dual gated edge flop
package gated_flop_pkg;
    typedef struct packed {
        logic gate_in_first;
        logic gate_in_second;
        logic gate_in_third;
        logic gate_in_fourth;
    } gate_group_type;
endpackage

// ===== design/dual_gated_edge_flop.sv
// Two independent flops clocked by a sampled gate function
//
// Behaviour
// RULE_01: Two independent channels, each own inputs
// RULE_02: Clear low forces stored output low
// RULE_03: Rising derived clock loads data input; the code does not load while i_rst is high
// RULE_04: Otherwise stored output holds its value
// RULE_05: First gate low: fourth, inverted if second&third
// RULE_06: First gate high: inverted fourth, except second-low third-high
// RULE_07: No defined start-up value before clear
// RULE_08: Board logic clears after power-up when needed
`timescale 1ns/1ps
`include "gated_flop_params.svh"

module dual_gated_edge_flop
    import gated_flop_pkg::*;
#(
    parameter int CHANNELS = `CHANNEL_COUNT
) (
    // Clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    // Per-channel inputs
    input  wire gate_group_type [CHANNELS-1:0] i_gates,
    input  wire logic [CHANNELS-1:0]   i_data,
    input  wire logic [CHANNELS-1:0]   i_async_clear_low,
    // Per-channel stored outputs
    output logic      [CHANNELS-1:0]   o_stored
);

    // Derived internal clock of one channel
    function automatic logic derive_clock(input gate_group_type g);
        logic inv;
        inv = 1'h0;
        if (!g.gate_in_first)
            inv = g.gate_in_second & g.gate_in_third;     // see RULE_05
        else
            inv = !(!g.gate_in_second & g.gate_in_third); // see RULE_06
        return g.gate_in_fourth ^ inv;
    endfunction

    // Clear pin decode, shared by next state and output
    function automatic logic is_cleared(input logic clear_pin);
        return clear_pin == `CLEAR_LEVEL;
    endfunction

    // Low-to-high step between two samples of a derived clock
    function automatic logic rose(input logic now_level, input logic last_level);
        return now_level && !last_level;
    endfunction

    // Per-channel derived clocks, edge history and stored bits
    logic [CHANNELS-1:0] clk_now;
    logic [CHANNELS-1:0] clk_prev;
    logic [CHANNELS-1:0] stored;
    logic [CHANNELS-1:0] next_stored;
    logic [CHANNELS-1:0] next_clk_prev;

    // One independent slice per channel, see RULE_01
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
            assign clk_now[ch] = derive_clock(i_gates[ch]);
        end
    endgenerate

    // Next state: clear, rising load, else hold. Edge history follows
    // the derived clock even in reset, so release brings no false edge
    always_comb begin
        next_clk_prev = clk_now;
        next_stored   = stored;                              // see RULE_04
        for (int i = 0; i < CHANNELS; i++) begin
            if (is_cleared(i_async_clear_low[i]))
                next_stored[i] = `CLEARED_VALUE;             // see RULE_02
            else if (!i_rst && rose(clk_now[i], clk_prev[i]))
                next_stored[i] = i_data[i];                  // see RULE_03
        end
    end

    // Registers only; stored value has no reset value, see RULE_07
    always_ff @(posedge i_clk) begin
        stored   <= next_stored;
        clk_prev <= next_clk_prev;
    end

    // Clear acts on the output at once, see RULE_02
    // The register alone would lag one edge behind a clear;
    // the override keeps the clear immediate at the pin
    always_comb begin
        for (int i = 0; i < CHANNELS; i++)
            o_stored[i] = is_cleared(i_async_clear_low[i]) ? `CLEARED_VALUE : stored[i];
    end

    // Checks, one set per channel; the gate decode is held against
    // the function table, edge behaviour against the pins

    // Clear low forces channel 0 output low
    property p_clear_out;
        @(posedge i_clk) disable iff (i_rst)
            !i_async_clear_low[0] |-> !o_stored[0];
    endproperty
    a_clear_out: assert property (p_clear_out) else $error("clear did not force low"); // see RULE_02

    // Clear low forces channel 1 output low
    property p_clear_out1;
        @(posedge i_clk) disable iff (i_rst)
            !i_async_clear_low[1] |-> !o_stored[1];
    endproperty
    a_clear_out1: assert property (p_clear_out1) else $error("clear did not force low, channel 1"); // see RULE_02

    // A cleared channel 1 stays low until its next rising edge
    property p_clear_held;
        @(posedge i_clk) disable iff (i_rst)
            !i_async_clear_low[1] ##1 i_async_clear_low[1] && !rose(clk_now[1], clk_prev[1]) |-> !o_stored[1];
    endproperty
    a_clear_held: assert property (p_clear_held) else $error("cleared value lost"); // see RULE_02

    // A cleared channel 0 stays low until its next rising edge
    property p_clear_held0;
        @(posedge i_clk) disable iff (i_rst)
            !i_async_clear_low[0] ##1 i_async_clear_low[0] && !rose(clk_now[0], clk_prev[0]) |-> !o_stored[0];
    endproperty
    a_clear_held0: assert property (p_clear_held0) else $error("cleared value lost, channel 0"); // see RULE_02

    // Rising derived clock loads channel 0 data
    property p_load;
        @(posedge i_clk) disable iff (i_rst)
            i_async_clear_low[0] && rose(clk_now[0], clk_prev[0])
                |=> o_stored[0] == $past(i_data[0]) || !i_async_clear_low[0];
    endproperty
    a_load: assert property (p_load) else $error("rising edge did not load"); // see RULE_03

    // Rising derived clock loads channel 1 data
    property p_load1;
        @(posedge i_clk) disable iff (i_rst)
            i_async_clear_low[1] && rose(clk_now[1], clk_prev[1])
                |=> o_stored[1] == $past(i_data[1]) || !i_async_clear_low[1];
    endproperty
    a_load1: assert property (p_load1) else $error("rising edge did not load, channel 1"); // see RULE_03

    // Channel 1 holds without a rising edge
    property p_hold;
        @(posedge i_clk) disable iff (i_rst)
            i_async_clear_low[1] && !rose(clk_now[1], clk_prev[1]) ##1 i_async_clear_low[1]
                |-> $stable(stored[1]);
    endproperty
    a_hold: assert property (p_hold) else $error("value changed without edge"); // see RULE_04

    // Channel 0 holds without a rising edge
    property p_hold0;
        @(posedge i_clk) disable iff (i_rst)
            i_async_clear_low[0] && !rose(clk_now[0], clk_prev[0]) ##1 i_async_clear_low[0]
                |-> $stable(stored[0]);
    endproperty
    a_hold0: assert property (p_hold0) else $error("value changed without edge, channel 0"); // see RULE_04

    // First gate low, channel 0
    property p_gate_low;
        @(posedge i_clk)
            !i_gates[0].gate_in_first |-> clk_now[0] == (i_gates[0].gate_in_fourth ^ (i_gates[0].gate_in_second & i_gates[0].gate_in_third));
    endproperty
    a_gate_low: assert property (p_gate_low) else $error("derived clock wrong, first low"); // see RULE_05

    // First gate low, channel 1
    property p_gate_low1;
        @(posedge i_clk)
            !i_gates[1].gate_in_first |-> clk_now[1] == (i_gates[1].gate_in_fourth ^ (i_gates[1].gate_in_second & i_gates[1].gate_in_third));
    endproperty
    a_gate_low1: assert property (p_gate_low1) else $error("derived clock wrong, first low, channel 1"); // see RULE_05

    // First gate high exception, channel 1
    property p_gate_high;
        @(posedge i_clk)
            i_gates[1].gate_in_first && !i_gates[1].gate_in_second && i_gates[1].gate_in_third |-> clk_now[1] == i_gates[1].gate_in_fourth;
    endproperty
    a_gate_high: assert property (p_gate_high) else $error("derived clock wrong, exception"); // see RULE_06

    // First gate high exception, channel 0
    property p_gate_high0;
        @(posedge i_clk)
            i_gates[0].gate_in_first && !i_gates[0].gate_in_second && i_gates[0].gate_in_third |-> clk_now[0] == i_gates[0].gate_in_fourth;
    endproperty
    a_gate_high0: assert property (p_gate_high0) else $error("derived clock wrong, exception, channel 0"); // see RULE_06

    // First gate high inverts, channel 0
    property p_gate_inv;
        @(posedge i_clk)
            i_gates[0].gate_in_first && (i_gates[0].gate_in_second || !i_gates[0].gate_in_third) |-> clk_now[0] != i_gates[0].gate_in_fourth;
    endproperty
    a_gate_inv: assert property (p_gate_inv) else $error("derived clock not inverted"); // see RULE_06

    // First gate high inverts, channel 1
    property p_gate_inv1;
        @(posedge i_clk)
            i_gates[1].gate_in_first && (i_gates[1].gate_in_second || !i_gates[1].gate_in_third) |-> clk_now[1] != i_gates[1].gate_in_fourth;
    endproperty
    a_gate_inv1: assert property (p_gate_inv1) else $error("derived clock not inverted, channel 1"); // see RULE_06

    // Clearing channel 0 leaves channel 1 alone
    property p_indep;
        @(posedge i_clk) disable iff (i_rst)
            !i_async_clear_low[0] && i_async_clear_low[1] && !rose(clk_now[1], clk_prev[1])
                |=> $stable(stored[1]) || !i_async_clear_low[1];
    endproperty
    a_indep: assert property (p_indep) else $error("channels interfere"); // see RULE_01

    // Clearing channel 1 leaves channel 0 alone
    property p_indep0;
        @(posedge i_clk) disable iff (i_rst)
            !i_async_clear_low[1] && i_async_clear_low[0] && !rose(clk_now[0], clk_prev[0])
                |=> $stable(stored[0]) || !i_async_clear_low[0];
    endproperty
    a_indep0: assert property (p_indep0) else $error("channels interfere, channel 0"); // see RULE_01

    // Main scenarios seen by the bench
    c_load_high: cover property (@(posedge i_clk) i_async_clear_low[0] && rose(clk_now[0], clk_prev[0]) && i_data[0]);
    c_clear: cover property (@(posedge i_clk) !i_async_clear_low[1] ##1 i_async_clear_low[1]);
    c_fall: cover property (@(posedge i_clk) i_async_clear_low[0] && !clk_now[0] && clk_prev[0]);
    c_load_ch1: cover property (@(posedge i_clk) i_async_clear_low[1] && rose(clk_now[1], clk_prev[1]) && i_data[1]);
    c_exception: cover property (@(posedge i_clk) i_gates[0].gate_in_first && !i_gates[0].gate_in_second && i_gates[0].gate_in_third);

endmodule

// ===== verification/board_logic.sv
// Board-side driver of gate, data and clear pins
`timescale 1ns/1ps
module board_logic
    import gated_flop_pkg::*;
(
    // Requests from the bench
    input  wire logic            i_rst,
    input  wire logic [7:0]      i_combo,
    input  wire logic [1:0]      i_data,
    input  wire logic [1:0]      i_clear,
    // Pins toward the block
    output gate_group_type [1:0] o_gates,
    output logic [1:0]           o_data,
    output logic [1:0]           o_async_clear_low
);
    // Pins follow requests; clear held low through power-up reset
    assign o_gates = i_combo;
    assign o_data = i_data;
    assign o_async_clear_low = i_rst ? 2'h0 : i_clear;
endmodule

// ===== verification/dual_gated_edge_flop_tb.sv
// Testbench for the dual gated edge flop
`timescale 1ns/1ps
module dual_gated_edge_flop_tb;
    import gated_flop_pkg::*;
    logic i_clk = 1'h0, i_rst = 1'h1, prev, e;
    logic [7:0] combo = 8'h00;
    logic [1:0] data = 2'h0, clear = 2'h3, d, clr, o_stored;
    gate_group_type [1:0] gates;
    int fails = 0, checks = 0, cyc = 0;
    localparam logic [15:0] y_table = 16'h596a; // Derived clock per gate pattern
    // Clock and cycle ceiling
    always #5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc++;
        if (cyc > 300) begin
            fails++;
            close_out();
        end
    end
    board_logic i_board_logic (.i_rst(i_rst), .i_combo(combo), .i_data(data), .i_clear(clear),
        .o_gates(gates), .o_data(d), .o_async_clear_low(clr));
    dual_gated_edge_flop i_dual_gated_edge_flop (.i_clk(i_clk), .i_rst(i_rst), .i_gates(gates),
        .i_data(d), .i_async_clear_low(clr), .o_stored(o_stored));
    task check(input logic [1:0] exp);
        checks++;
        if (o_stored !== exp) begin
            fails++;
            $display("wrong value t=%0t got=%h exp=%h", $time, o_stored, exp);
        end
    endtask
    task close_out();
        $display("fails=%0d checks=%0d", fails, checks);
        if (fails == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Apply inputs at a falling edge, let one rising edge pass
    task step(input logic [7:0] c, input logic [1:0] dv);
        @(negedge i_clk);
        combo = c;
        data = dv;
        @(negedge i_clk);
    endtask
    // Walk all sixteen gate patterns on channel 0
    task test_table();
        prev = 1'h0;
        for (int k = 0; k < 16; k++) begin
            step(8'h00, {1'h1, ~prev});
            check({1'h0, prev});
            e = y_table[k];
            step({4'h0, 4'(k)}, {1'h1, ~prev});
            prev = e ? ~prev : prev;
            check({1'h0, prev});
        end
    endtask
    // Clear in mid-run acts at once on its own channel
    task test_clear();
        step(8'h01, 2'h1);
        check(2'h1);
        @(negedge i_clk);
        clear = 2'h2;
        #1 check(2'h0);
        @(negedge i_clk);
        clear = 2'h3;
        @(negedge i_clk);
        check(2'h0);
    endtask
    // Channel 1 loads and clears while channel 0 holds
    task test_indep();
        step(8'h00, 2'h2);
        check(2'h0);
        step(8'h10, 2'h2);
        check(2'h2);
        @(negedge i_clk);
        clear = 2'h1;
        #1 check(2'h0);
        @(negedge i_clk);
        clear = 2'h3;
        @(negedge i_clk);
        check(2'h0);
    endtask
    initial begin
        repeat (16) @(negedge i_clk);
        check(2'h0);
        i_rst = 1'h0;
        test_table();
        test_clear();
        test_indep();
        close_out();
    end
endmodule
